//--- testbench/smac_host_model.sv
// host bus partner issuing management-aware memory cycles
`timescale 1ns/1ps
module smac_host_model (
  // clock
  input  wire logic        i_core_clk,
  // host memory cycle
  output logic             o_host_address_strobe,
  output logic [31:0]      o_host_addr,
  output logic             o_host_mgmt_mode,
  output logic             o_host_code_ref
);
  // ------------------------------------------------------------
  // one strobe per call
  // ------------------------------------------------------------
  initial begin
    o_host_address_strobe = 1'b0;
    o_host_addr           = 32'h0;
    o_host_mgmt_mode      = 1'b0;
    o_host_code_ref       = 1'b0;
  end
  // qualifiers are inverted once the cycle is gone, so a design that
  // samples them late sees garbage rather than a lucky stale value
  task automatic cycle(input logic [31:0] a, input logic m, input logic c);
    @(negedge i_core_clk);
    o_host_address_strobe = 1'b1;
    o_host_addr           = a;
    o_host_mgmt_mode      = m;
    o_host_code_ref       = c;
    @(negedge i_core_clk);
    o_host_address_strobe = 1'b0;
    o_host_addr           = ~a;
    o_host_mgmt_mode      = ~m;
    o_host_code_ref       = ~c;
  endtask
endmodule

//--- testbench/smm_memory_access_control_tb.sv
// self-checking bench for the management memory access control block
`timescale 1ns/1ps
module smm_memory_access_control_tb;
  import smac_pkg::*;
  typedef struct packed {
    logic        d;
    logic        h;
    logic        c;
    logic [31:0] a;
  } smac_note_s;
  logic        clk;
  logic        rst;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  rdata;
  logic        stb;
  logic [31:0] haddr;
  logic        mgmt;
  logic        code;
  logic        rv;
  logic        dram;
  logic        hub;
  logic [31:0] daddr;
  logic        cach;
  logic        stb_q;
  logic        rd_q;
  logic [15:0] lfsr;
  smac_note_s  notes[$];
  logic [7:0]  reads[$];
  int          mismatches;
  int          compares;
  // ------------------------------------------------------------
  // design and host partner
  // ------------------------------------------------------------
  smac_top uut (
    .i_core_clk(clk), .i_rst(rst), .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd),
    .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(rdata),
    .i_top_of_memory(32'h20000000), .i_host_address_strobe(stb),
    .i_host_addr(haddr), .i_host_mgmt_mode(mgmt), .i_host_code_ref(code),
    .o_resp_valid(rv), .o_to_dram(dram), .o_to_hub(hub),
    .o_dram_addr(daddr), .o_cacheable(cach));
  smac_host_model host (
    .i_core_clk(clk), .o_host_address_strobe(stb), .o_host_addr(haddr),
    .o_host_mgmt_mode(mgmt), .o_host_code_ref(code));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string m);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reads.push_back(e);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
  endtask
  task automatic hc(input logic [31:0] a, input logic m, input logic c,
                    input logic [2:0] r, input logic [31:0] da);
    notes.push_back({r, da});
    host.cycle(a, m, c);
  endtask
  // ------------------------------------------------------------
  // result watcher: oldest note against each answer
  // ------------------------------------------------------------
  always @(posedge clk) begin
    stb_q <= stb;
    rd_q <= cfg_rd;
  end
  always @(negedge clk) begin
    smac_note_s n;
    if (!rst) begin
      check(32'(rv), 32'(stb_q), "answer timing");
      if (rv && notes.size() == 0) begin
        check(32'h1, 32'h0, "answer without cycle");
      end else if (rv) begin
        n = notes.pop_front();
        check(32'({dram, hub, cach}), 32'({n.d, n.h, n.c}), "routing");
        if (n.d) begin
          check(daddr, n.a, "dram address");
        end
      end
      if (rd_q) begin
        check(32'(rdata), 32'(reads.pop_front()), "read data");
      end
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h0;
    cfg_wdata = 8'h0;
    lfsr = 16'h89ea;
    mismatches = 0;
    compares = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(SMAC_OFS_MGMT_CTL, 8'h02);
    rd(SMAC_OFS_EXT_CTL, 8'h38);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lfsr = step(lfsr);
      hc({16'h0001, lfsr}, lfsr[3], lfsr[7], 3'b100, {16'h0001, lfsr});
    end
    wr(SMAC_OFS_MGMT_CTL, 8'h40);
    rd(SMAC_OFS_MGMT_CTL, 8'h42);
    hc(32'h000a0000, 1'b0, 1'b0, 3'b010, 32'h0);
    hc(32'h000a0000, 1'b1, 1'b0, 3'b010, 32'h0);
    wr(SMAC_OFS_MGMT_CTL, 8'h08);
    hc(32'h000bfffc, 1'b1, 1'b0, 3'b100, 32'h000bfffc);
    hc(32'h000a0010, 1'b0, 1'b0, 3'b010, 32'h0);
    hc(32'h000c0000, 1'b1, 1'b0, 3'b100, 32'h000c0000);
    wr(SMAC_OFS_MGMT_CTL, 8'h28);
    hc(32'h000a0100, 1'b1, 1'b0, 3'b010, 32'h0);
    hc(32'h000a0100, 1'b1, 1'b1, 3'b100, 32'h000a0100);
    wr(SMAC_OFS_MGMT_CTL, 8'h48);
    hc(32'h000b0000, 1'b0, 1'b0, 3'b100, 32'h000b0000);
    wr(SMAC_OFS_EXT_CTL, 8'h87);
    rd(SMAC_OFS_EXT_CTL, 8'hbf);
    hc(32'hfeda0040, 1'b0, 1'b0, 3'b101, 32'h000a0040);
    wr(SMAC_OFS_MGMT_CTL, 8'h28);
    for (int i = 0; i < 4; i++) begin
      lfsr = step(lfsr);
      hc({15'h7f6d, lfsr[0], lfsr}, 1'b1, 1'b0, 3'b101,
         {15'h0005, lfsr[0], lfsr});
    end
    hc(32'h0ff00000, 1'b1, 1'b0, 3'b101, 32'h0ff00000);
    hc(32'h0fe00000, 1'b0, 1'b0, 3'b100, 32'h0fe00000);
    hc(32'h0fffff00, 1'b0, 1'b0, 3'b010, 32'h0);
    hc(32'h10000000, 1'b1, 1'b0, 3'b010, 32'h0);
    rd(SMAC_OFS_EXT_CTL, 8'hff);
    wr(SMAC_OFS_EXT_CTL, 8'h87);
    rd(SMAC_OFS_EXT_CTL, 8'hff);
    wr(SMAC_OFS_EXT_CTL, 8'hc5);
    rd(SMAC_OFS_EXT_CTL, 8'hbd);
    hc(32'h0ff00000, 1'b0, 1'b0, 3'b100, 32'h0ff00000);
    hc(32'h0ff80000, 1'b0, 1'b1, 3'b010, 32'h0);
    wr(SMAC_OFS_MGMT_CTL, 8'h00);
    hc(32'hfeda0000, 1'b1, 1'b0, 3'b010, 32'h0);
    hc(32'h10000000, 1'b0, 1'b0, 3'b100, 32'h10000000);
    do_reset();
    rd(SMAC_OFS_MGMT_CTL, 8'h02);
    wr(SMAC_OFS_EXT_CTL, 8'h85);
    wr(SMAC_OFS_MGMT_CTL, 8'h48);
    wr(SMAC_OFS_MGMT_CTL, 8'h08);
    wr(SMAC_OFS_MGMT_CTL, 8'h18);
    rd(SMAC_OFS_MGMT_CTL, 8'h1a);
    wr(SMAC_OFS_MGMT_CTL, 8'h40);
    rd(SMAC_OFS_MGMT_CTL, 8'h1a);
    wr(SMAC_OFS_EXT_CTL, 8'h04);
    rd(SMAC_OFS_EXT_CTL, 8'hbd);
    wr(SMAC_OFS_MGMT_CTL, 8'h38);
    rd(SMAC_OFS_MGMT_CTL, 8'h3a);
    hc(32'hfedbfff0, 1'b1, 1'b0, 3'b101, 32'h000bfff0);
    do_reset();
    rd(SMAC_OFS_MGMT_CTL, 8'h02);
    rd(SMAC_OFS_EXT_CTL, 8'h38);
    for (int i = 0; i < 20 && (notes.size() + reads.size()) > 0; i++) begin
      @(negedge clk);
    end
    if ((notes.size() + reads.size()) > 0) begin
      check(32'h1, 32'h0, "results never came");
    end
    complete_run();
  end
endmodule

//--- verilog/smac_decode.sv
// address window decode for the management memory block
`timescale 1ns/1ps
module smac_decode
  import smac_pkg::*;
(
  // access address and memory limit
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_tom_eff,
  input  wire logic [1:0]  i_tseg_size,
  // window hits
  output logic             o_compat_hit,
  output logic             o_high_hit,
  output logic             o_tseg_hit,
  output logic             o_tseg_size_ok,
  output logic             o_below_tom
);
  // --------------------------------------------------------------
  // range check
  // --------------------------------------------------------------
  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction

  wire logic [31:0] tseg_len;
  wire logic [31:0] tseg_base;

  assign o_tseg_size_ok = (i_tseg_size == SMAC_TSZ_512K) ||
                          (i_tseg_size == SMAC_TSZ_1M);
  assign tseg_len  = (i_tseg_size == SMAC_TSZ_1M) ? SMAC_ONE_MB
                                                   : SMAC_HALF_MB;
  // a memory limit below the segment size would wrap; clamp to zero
  assign tseg_base = (i_tom_eff > tseg_len) ? (i_tom_eff - tseg_len)
                                            : 32'h00000000;
  assign o_compat_hit = in_range(i_addr, SMAC_COMPAT_LO,
                                 SMAC_COMPAT_HI);
  assign o_high_hit   = in_range(i_addr, SMAC_HIGH_LO,
                                 SMAC_HIGH_HI);
  assign o_tseg_hit   = in_range(i_addr, tseg_base, i_tom_eff);
  assign o_below_tom  = i_addr < i_tom_eff;
endmodule

//--- verilog/smac_pkg.sv
// constants for the management memory access control block
package smac_pkg;
  // --------------------------------------------------------------
  // configuration offsets and reset values
  // --------------------------------------------------------------
  localparam logic [7:0] SMAC_OFS_MGMT_CTL = 8'h9d;
  localparam logic [7:0] SMAC_OFS_EXT_CTL  = 8'h9e;
  localparam logic [7:0] SMAC_RST_MGMT_CTL = 8'h02;
  localparam logic [7:0] SMAC_RST_EXT_CTL  = 8'h38;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int SMAC_B_OPEN   = 6;
  localparam int SMAC_B_CLOSED = 5;
  localparam int SMAC_B_LOCK   = 4;
  localparam int SMAC_B_GEN    = 3;
  localparam int SMAC_B_HEN    = 7;
  localparam int SMAC_B_ERR    = 6;
  localparam int SMAC_B_TEN    = 0;
  localparam logic [2:0] SMAC_COMPAT_SEG = 3'h2;
  localparam logic [2:0] SMAC_EXT_RO_ONE = 3'h7;
  localparam logic [1:0] SMAC_TSZ_512K   = 2'h2;
  localparam logic [1:0] SMAC_TSZ_1M     = 2'h3;
  // --------------------------------------------------------------
  // address map
  // --------------------------------------------------------------
  localparam logic [31:0] SMAC_COMPAT_LO = 32'h000a0000;
  localparam logic [31:0] SMAC_COMPAT_HI = 32'h000c0000;
  localparam logic [31:0] SMAC_HIGH_LO   = 32'hfeda0000;
  localparam logic [31:0] SMAC_HIGH_HI   = 32'hfedc0000;
  localparam logic [31:0] SMAC_ONE_MB    = 32'h00100000;
  localparam logic [31:0] SMAC_HALF_MB   = 32'h00080000;
  localparam logic [31:0] SMAC_DRAM_CAP  = 32'h10000000;
  localparam int          SMAC_REMAP_W   = 20;
endpackage

//--- verilog/smac_top.sv
// management memory access control: registers, routing, flags
`timescale 1ns/1ps
module smac_top
  import smac_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // configuration space access
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [7:0]  i_cfg_wdata,
  output logic [7:0]       o_cfg_rdata,
  // memory limit from the dram map
  input  wire logic [31:0] i_top_of_memory,
  // host memory cycle
  input  wire logic        i_host_address_strobe,
  input  wire logic [31:0] i_host_addr,
  input  wire logic        i_host_mgmt_mode,
  input  wire logic        i_host_code_ref,
  // routing answer
  output logic             o_resp_valid,
  output logic             o_to_dram,
  output logic             o_to_hub,
  output logic [31:0]      o_dram_addr,
  output logic             o_cacheable
);
  // --------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------
  logic       open_r;
  logic       closed_r;
  logic       lock_r;
  logic       gen_r;
  logic       hen_r;
  logic       err_r;
  logic [1:0] tsz_r;
  logic       ten_r;
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       to_dram_r;
  logic       to_hub_r;
  logic [31:0] dram_addr_r;
  logic       cache_r;

  wire logic wr_mgmt;
  wire logic wr_ext;
  wire logic rd_mgmt;
  wire logic rd_ext;
  wire logic open_nxt;
  wire logic closed_nxt;
  wire logic lock_nxt;
  wire logic gen_nxt;
  wire logic hen_nxt;
  wire logic err_nxt;
  wire logic [1:0] tsz_nxt;
  wire logic ten_nxt;
  wire logic [7:0] mgmt_val;
  wire logic [7:0] ext_val;
  wire logic [7:0] rdata_nxt;

  assign wr_mgmt = i_cfg_wr && (i_cfg_addr == SMAC_OFS_MGMT_CTL);
  assign wr_ext  = i_cfg_wr && (i_cfg_addr == SMAC_OFS_EXT_CTL);
  assign rd_mgmt = i_cfg_rd && (i_cfg_addr == SMAC_OFS_MGMT_CTL);
  assign rd_ext  = i_cfg_rd && (i_cfg_addr == SMAC_OFS_EXT_CTL);

  // lock only ever accumulates; no write path can drop it
  assign lock_nxt = lock_r | (wr_mgmt & i_cfg_wdata[SMAC_B_LOCK]);
  // setting lock in the same write forces open low; software is
  // expected to have cleared open first anyway
  assign open_nxt = lock_nxt ? 1'b0 :
                    wr_mgmt ? i_cfg_wdata[SMAC_B_OPEN] : open_r;
  assign closed_nxt = wr_mgmt ? i_cfg_wdata[SMAC_B_CLOSED]
                              : closed_r;
  assign gen_nxt = (wr_mgmt && !lock_r) ? i_cfg_wdata[SMAC_B_GEN]
                                        : gen_r;
  assign hen_nxt = (wr_ext && !lock_r) ? i_cfg_wdata[SMAC_B_HEN]
                                       : hen_r;
  assign tsz_nxt = (wr_ext && !lock_r) ? i_cfg_wdata[2:1] : tsz_r;
  assign ten_nxt = (wr_ext && !lock_r) ? i_cfg_wdata[SMAC_B_TEN]
                                       : ten_r;

  // --------------------------------------------------------------
  // access routing
  // --------------------------------------------------------------
  wire logic        ext_in_use;
  wire logic [31:0] tom_eff;
  wire logic        compat_hit;
  wire logic        high_hit;
  wire logic        tseg_hit;
  wire logic        tseg_size_ok;
  wire logic        below_tom;
  wire logic        open_eff;
  wire logic        closed_eff;
  wire logic        high_act;
  wire logic        tseg_act;
  wire logic        compat_ok;
  wire logic        ext_ok;
  wire logic        violation;
  wire logic        route_dram;
  wire logic [31:0] route_addr;
  wire logic        route_cache;

  assign ext_in_use = gen_r && (hen_r || ten_r);
  assign tom_eff = (ext_in_use && i_top_of_memory > SMAC_DRAM_CAP)
                   ? SMAC_DRAM_CAP : i_top_of_memory;

  smac_decode u_decode (
    .i_addr         (i_host_addr),
    .i_tom_eff      (tom_eff),
    .i_tseg_size    (tsz_r),
    .o_compat_hit   (compat_hit),
    .o_high_hit     (high_hit),
    .o_tseg_hit     (tseg_hit),
    .o_tseg_size_ok (tseg_size_ok),
    .o_below_tom    (below_tom)
  );

  // open/closed count for nothing while the global enable is low
  assign open_eff   = gen_r && open_r && !lock_r;
  assign closed_eff = gen_r && closed_r;
  assign high_act = gen_r && hen_r && high_hit;
  assign tseg_act = gen_r && ten_r && tseg_size_ok && tseg_hit;
  // closed looks at the compatible window alone; mode ref
  assign compat_ok = gen_r && (open_eff ||
                     (i_host_mgmt_mode &&
                      !(closed_eff && !i_host_code_ref)));
  assign ext_ok = i_host_mgmt_mode || open_eff;
  assign violation = i_host_address_strobe && (high_act || tseg_act)
                     && !i_host_mgmt_mode && !open_r;
  // no remap below 1 MB: a refused compatible access is not dram
  assign route_dram = compat_hit ? compat_ok :
                      (high_act || tseg_act) ? ext_ok :
                      below_tom;
  assign route_addr = high_act
    ? {SMAC_COMPAT_LO[31:SMAC_REMAP_W],
       i_host_addr[SMAC_REMAP_W-1:0]}
    : i_host_addr;
  assign route_cache = (high_act || tseg_act) && route_dram;

  // --------------------------------------------------------------
  // error flag and read data
  // --------------------------------------------------------------
  // a new violation in the clearing cycle keeps the flag set
  assign err_nxt = violation ? 1'b1 :
                   (wr_ext && i_cfg_wdata[SMAC_B_ERR]) ? 1'b0 :
                   err_r;
  assign mgmt_val = {1'b0, open_r, closed_r, lock_r, gen_r,
                     SMAC_COMPAT_SEG};
  assign ext_val = {hen_r, err_r, SMAC_EXT_RO_ONE, tsz_r,
                    ten_r};
  assign rdata_nxt = rd_mgmt ? mgmt_val :
                     rd_ext  ? ext_val  :
                     i_cfg_rd ? 8'h00 : rdata_r;

  // --------------------------------------------------------------
  // flops
  // --------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      open_r   <= SMAC_RST_MGMT_CTL[SMAC_B_OPEN];
      closed_r <= SMAC_RST_MGMT_CTL[SMAC_B_CLOSED];
      lock_r   <= SMAC_RST_MGMT_CTL[SMAC_B_LOCK];
      gen_r    <= SMAC_RST_MGMT_CTL[SMAC_B_GEN];
    end else begin
      open_r   <= open_nxt;
      closed_r <= closed_nxt;
      lock_r   <= lock_nxt;
      gen_r    <= gen_nxt;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hen_r <= SMAC_RST_EXT_CTL[SMAC_B_HEN];
      err_r <= SMAC_RST_EXT_CTL[SMAC_B_ERR];
      tsz_r <= SMAC_RST_EXT_CTL[2:1];
      ten_r <= SMAC_RST_EXT_CTL[SMAC_B_TEN];
    end else begin
      hen_r <= hen_nxt;
      err_r <= err_nxt;
      tsz_r <= tsz_nxt;
      ten_r <= ten_nxt;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // routing answer one cycle after the strobe
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r    <= 1'b0;
      to_dram_r   <= 1'b0;
      to_hub_r    <= 1'b0;
      dram_addr_r <= 32'h00000000;
      cache_r     <= 1'b0;
    end else begin
      rvalid_r    <= i_host_address_strobe;
      to_dram_r   <= i_host_address_strobe && route_dram;
      to_hub_r    <= i_host_address_strobe && !route_dram;
      dram_addr_r <= i_host_address_strobe ? route_addr : dram_addr_r;
      cache_r     <= i_host_address_strobe && route_cache;
    end
  end

  assign o_cfg_rdata  = rdata_r;
  assign o_resp_valid = rvalid_r;
  assign o_to_dram    = to_dram_r;
  assign o_to_hub     = to_hub_r;
  assign o_dram_addr  = dram_addr_r;
  assign o_cacheable  = cache_r;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence lock_write_s;
    wr_mgmt && i_cfg_wdata[SMAC_B_LOCK];
  endsequence
  sequence frozen_s;
    $stable(gen_r) && $stable(hen_r) && $stable(tsz_r) &&
      $stable(ten_r) && !open_r;
  endsequence
  sequence compat_data_s;
    i_host_address_strobe && compat_hit && i_host_mgmt_mode &&
      !i_host_code_ref;
  endsequence

  lock_sticky_a: assert property (lock_r |=> lock_r)
    else $error("lock bit dropped without reset");
  lock_freeze_a: assert property (
    lock_write_s |=> lock_r ##1 frozen_s [*3])
    else $error("locked fields changed or open stayed set");
  closed_data_a: assert property (
    compat_data_s ##0 closed_eff ##0 !open_eff |=> o_resp_valid && o_to_hub)
    else $error("closed window let a data reference reach dram");
  open_reach_a: assert property (
    i_host_address_strobe && compat_hit && gen_r && open_r && !lock_r
    |=> o_to_dram)
    else $error("open window did not reach dram");
  global_off_a: assert property (
    i_host_address_strobe && compat_hit && !gen_r |=> o_to_hub && !o_to_dram)
    else $error("compatible window claimed with global enable off");
  high_remap_a: assert property (
    i_host_address_strobe && high_hit && gen_r && hen_r && i_host_mgmt_mode
    |=> o_to_dram && o_dram_addr == {12'h000, $past(i_host_addr[19:0])})
    else $error("high window not remapped onto the low window");
  err_cause_a: assert property ($rose(err_r) |-> $past(violation))
    else $error("invalid access flag set without a cause");
  err_set_a: assert property (violation |=> err_r)
    else $error("invalid access did not set the flag");
  err_hold_a: assert property (
    err_r && !(wr_ext && i_cfg_wdata[SMAC_B_ERR]) |=> err_r)
    else $error("invalid access flag cleared without a one write");

  closed_high_a: assert property (
    i_host_address_strobe && high_act && i_host_mgmt_mode && closed_eff
    |=> o_to_dram)
    else $error("closed bit blocked the high window");
  tseg_hub_a: assert property (
    i_host_address_strobe && tseg_act && !i_host_mgmt_mode && !open_eff
    |=> o_to_hub && !o_cacheable)
    else $error("active top segment claimed outside management mode");
  dram_cap_a: assert property (
    i_host_address_strobe && ext_in_use && !high_act &&
    i_host_addr >= SMAC_DRAM_CAP |=> !o_to_dram)
    else $error("dram claimed above the extended memory limit");
  compat_flat_a: assert property (
    i_host_address_strobe && compat_hit |=> o_dram_addr == $past(i_host_addr))
    else $error("compatible window address was remapped");
  route_one_a: assert property (
    o_resp_valid |-> o_to_dram ^ o_to_hub)
    else $error("answer went to both or neither destination");
  cache_ext_a: assert property (
    o_cacheable |-> o_to_dram && $past(high_act || tseg_act))
    else $error("cacheable flag outside the extended region");
  gen_locked_a: assert property (lock_r |=> $stable(gen_r))
    else $error("global enable changed while locked");
  locked_hold_a: assert property (
    lock_r |=> $stable(hen_r) && $stable(tsz_r) && $stable(ten_r) &&
    !open_r)
    else $error("locked extended fields changed or open set");
  compat_claim_a: assert property (
    i_host_address_strobe && compat_hit && gen_r && i_host_mgmt_mode &&
    !closed_eff |=> o_to_dram)
    else $error("management access to the compatible window not claimed");
  ext_gate_a: assert property (
    i_host_address_strobe && high_hit && !gen_r |=> !o_cacheable &&
    o_dram_addr == $past(i_host_addr))
    else $error("high window active with global enable off");
  hard_bits_a: assert property (rd_ext |=> o_cfg_rdata[5:3] == 3'h7)
    else $error("hardwired cache bits do not read one");
  base_seg_a: assert property (rd_mgmt |=> o_cfg_rdata[2:0] == 3'h2)
    else $error("base segment field not hardwired");
endmodule
